// ---- shared/dcsfc_defs.svh ----
// offsets, field positions, reset values and timing counts for the switch fault control
`ifndef DCSFC_DEFS_SVH
`define DCSFC_DEFS_SVH
// ------------------------------------------------------------
// register offsets (byte addresses)
// ------------------------------------------------------------
`define DCSFC_A_CTRL0 8'h00
`define DCSFC_A_CTRL1 8'h04
`define DCSFC_A_FAULT0 8'h08
`define DCSFC_A_FAULT1 8'h0C
`define DCSFC_A_STAT0 8'h10
`define DCSFC_A_STAT1 8'h14
// ------------------------------------------------------------
// field positions
// ------------------------------------------------------------
`define DCSFC_B_HI 0
`define DCSFC_B_LO 1
`define DCSFC_B_CUR 2
`define DCSFC_B_ON 3
`define DCSFC_B_PBAD 3
`define DCSFC_B_BOARD 4
// ------------------------------------------------------------
// reset values
// ------------------------------------------------------------
`define DCSFC_CTRL_RST 4'h3
`define DCSFC_FAULT_RST 6'h00
// ------------------------------------------------------------
// timing: figures as printed, counts at the clock rate
// ------------------------------------------------------------
`define DCSFC_CLK_MHZ 50
`define DCSFC_T_SUPPLY_NS 1000
`define DCSFC_T_FILT_NS 2000
`define DCSFC_T_BRK_NS 20000
`define DCSFC_T_QUAL_MS 100
`define DCSFC_T_COOL_S 5
`define DCSFC_SUPPLY_CYC ((`DCSFC_T_SUPPLY_NS * `DCSFC_CLK_MHZ + 999) / 1000)
`define DCSFC_FILT_CYC ((`DCSFC_T_FILT_NS * `DCSFC_CLK_MHZ + 999) / 1000)
`define DCSFC_BRK_CYC ((`DCSFC_T_BRK_NS * `DCSFC_CLK_MHZ + 999) / 1000)
`define DCSFC_QUAL_CYC (`DCSFC_T_QUAL_MS * `DCSFC_CLK_MHZ * 1000)
`define DCSFC_COOL_CYC (`DCSFC_T_COOL_S * `DCSFC_CLK_MHZ * 1000000)
`endif

// ---- shared/dcsfc_pkg.sv ----
// types shared by the switch fault control
package dcsfc_pkg;
  // ------------------------------------------------------------
  // per-channel sensed inputs
  // ------------------------------------------------------------
  typedef struct packed {
    logic on_req;
    logic input_high_sense;
    logic input_low_sense;
    logic board_absent;
    logic breaker;
    logic in_limit;
    logic output_feedback_sense;
    logic gs_enhanced;
    logic vdd_low;
  } dcsfc_ch_in_s;
  // ------------------------------------------------------------
  // shared inputs
  // ------------------------------------------------------------
  typedef struct packed {
    logic internal_supply_low;
    logic internal_timer;
    logic timer_high;
    logic timer_low;
    logic link_indep;
  } dcsfc_sh_in_s;
  typedef enum logic [1:0] {
    ST_OFF,
    ST_START,
    ST_RUN
  } dcsfc_state_e;
endpackage : dcsfc_pkg

// ---- design/dcsfc_top.sv ----
// switch fault control for two power-path channels
// What this block does
// - on-request fall or software turn-off command starts a normal channel turn-off.
// - input high, input low, breaker trip or board removal turn the channel off.
// - software writing one to fault bits 0-2 latches off unless retry set.
// - internal supply low over 1 us or channel supply low over 2 us: fast off.
// - current fault sets fault bit 2; turns off channel, or both when coupled.
// - still in current limit at start timer end declares current fault, turns off.
// - restart after current fault waits cool-down and needs bit clear or retry.
// - breaker excess starts a 20 us timer; trips if still excessive at end.
// - after breaker trip stay off unless retry; then 100 ms or 5 s cool-down.
// - input high over 2 us turns channel off, sets present and fault bit 0.
// - input high absent 100 ms lets channel turn on unless its retry cleared.
// - input low over filter time turns channel off, sets present and fault bit 1.
// - input low absent 100 ms turns channel on unless its retry cleared.
// - input low when internal supply first comes up logs a low-input fault.
// - coupled mode: input high or low on either channel shuts both off.
// - on-request rising edge sets switch_on_bit, falling edge clears it.
// - on-request rising edge turns channel on at once, no 100 ms qualification.
// - cycling on-request cancels current cool-down; restart after 100 ms.
// - coupled mode starts both only when all conditions allow, stops both together.
// - power good only after start timer, with feedback and gate enhancement good.
// - software clears fault bits 0-5 by writing zeros; present faults stay set.
//
// Chosen here: the address map and strobed register access.
module dcsfc_filt #(
  parameter int unsigned N = 1
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic lvl,
  output logic hit
);
  logic [9:0] cnt_reg;
  logic hit_reg;

  // counts the run of high cycles; any low cycle restarts it
  always_ff @(posedge clk) begin
    if (srst || !lvl) begin
      cnt_reg <= 10'h000;
    end else if (cnt_reg != N[9:0]) begin
      cnt_reg <= cnt_reg + 10'h001;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      hit_reg <= 1'b0;
    end else begin
      hit_reg <= lvl && (cnt_reg == N[9:0]);
    end
  end

  assign hit = hit_reg;
endmodule : dcsfc_filt

`include "dcsfc_defs.svh"

module dcsfc_top #(
  parameter int unsigned QUAL_CYC = `DCSFC_QUAL_CYC,
  parameter int unsigned COOL_CYC = `DCSFC_COOL_CYC
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [7:0] rdata,
  input wire dcsfc_pkg::dcsfc_ch_in_s [1:0] ch_in,
  input wire dcsfc_pkg::dcsfc_sh_in_s sh_in,
  output logic [1:0] gate_on,
  output logic [1:0] fast_off,
  output logic [1:0] power_good
);
  import dcsfc_pkg::*;

  // ------------------------------------------------------------
  // shared inputs
  // ------------------------------------------------------------
  dcsfc_sh_in_s sh1_reg;
  dcsfc_sh_in_s sh_reg;
  logic supply_f;
  logic pu_pend_reg;
  logic [1:0] go_w;
  logic [1:0][3:0] ctrl_w;
  logic [1:0][5:0] fault_w;
  logic [1:0][4:0] stat_w;
  logic [7:0] rdata_reg;

  // no reset: pin levels must be valid the moment reset lifts
  always_ff @(posedge clk) begin
    sh1_reg <= sh_in;
    sh_reg <= sh1_reg;
  end

  dcsfc_filt #(.N(`DCSFC_SUPPLY_CYC)) u_supply (
    .clk(clk),
    .srst(srst),
    .lvl(sh_reg.internal_supply_low),
    .hit(supply_f)
  );

  // armed by reset, spent the first cycle the internal supply is up
  always_ff @(posedge clk) begin
    if (srst) begin
      pu_pend_reg <= 1'b1;
    end else if (!sh_reg.internal_supply_low) begin
      pu_pend_reg <= 1'b0;
    end
  end

  // ------------------------------------------------------------
  // channels
  // ------------------------------------------------------------
  for (genvar i = 0; i < 2; i++) begin : g_ch
    localparam logic [7:0] A_CTRL = (i == 0) ? `DCSFC_A_CTRL0 : `DCSFC_A_CTRL1;
    localparam logic [7:0] A_FAULT = (i == 0) ? `DCSFC_A_FAULT0 : `DCSFC_A_FAULT1;
    dcsfc_ch_in_s s1_reg;
    dcsfc_ch_in_s s_reg;
    logic hi_f;
    logic lo_f;
    logic vdd_f;
    logic brk_f;
    logic on_q_reg;
    logic abs_q_reg;
    logic on_rise;
    logic on_fall;
    logic insert;
    logic remove;
    logic [3:0] ctrl_reg;
    logic [5:0] fault_reg;
    logic [5:0] fault_next;
    logic [5:0] pres;
    logic [27:0] qual_reg;
    logic qual_done;
    logic qual_q_reg;
    logic cond_ok;
    logic blocked;
    logic go_eff;
    dcsfc_state_e st_reg;
    logic [27:0] tmr_reg;
    logic start_end;
    logic trip;
    logic pbad;
    logic cool_reg;
    logic need_pin_reg;
    logic [27:0] cool_cnt_reg;
    logic pg_reg;
    logic fo_reg;

    // no reset: the power-up low-input check needs the real pin at once
    always_ff @(posedge clk) begin
      s1_reg <= ch_in[i];
      s_reg <= s1_reg;
    end

    dcsfc_filt #(.N(`DCSFC_FILT_CYC)) u_hi (
      .clk(clk),
      .srst(srst),
      .lvl(s_reg.input_high_sense),
      .hit(hi_f)
    );
    dcsfc_filt #(.N(`DCSFC_FILT_CYC)) u_lo (
      .clk(clk),
      .srst(srst),
      .lvl(s_reg.input_low_sense),
      .hit(lo_f)
    );
    dcsfc_filt #(.N(`DCSFC_FILT_CYC)) u_vdd (
      .clk(clk),
      .srst(srst),
      .lvl(s_reg.vdd_low),
      .hit(vdd_f)
    );
    dcsfc_filt #(.N(`DCSFC_BRK_CYC)) u_brk (
      .clk(clk),
      .srst(srst),
      .lvl(s_reg.breaker),
      .hit(brk_f)
    );

    // ------------------------------------------------------------
    // pin edges
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
      if (srst) begin
        on_q_reg <= 1'b0;
        abs_q_reg <= 1'b0;
      end else begin
        on_q_reg <= s_reg.on_req;
        abs_q_reg <= s_reg.board_absent;
      end
    end

    assign on_rise = s_reg.on_req && !on_q_reg;
    assign on_fall = !s_reg.on_req && on_q_reg;
    assign insert = abs_q_reg && !s_reg.board_absent;
    assign remove = !abs_q_reg && s_reg.board_absent;

    // ------------------------------------------------------------
    // control: retry bits 0-2, switch_on_bit 3
    // ------------------------------------------------------------
    // pin edges come last so they win over a write in the same cycle
    always_ff @(posedge clk) begin
      if (srst) begin
        ctrl_reg <= `DCSFC_CTRL_RST;
      end else begin
        if (wr && addr == A_CTRL) begin
          ctrl_reg <= wdata[3:0];
        end
        if (qual_done && !qual_q_reg) begin
          ctrl_reg[`DCSFC_B_ON] <= s_reg.on_req;
        end
        if (on_rise) begin
          ctrl_reg[`DCSFC_B_ON] <= 1'b1;
        end
        if (on_fall) begin
          ctrl_reg[`DCSFC_B_ON] <= 1'b0;
        end
      end
    end

    // ------------------------------------------------------------
    // 100 ms qualification of the level conditions
    // ------------------------------------------------------------
    assign cond_ok = !hi_f && !lo_f && !s_reg.board_absent && !vdd_f && !supply_f;

    always_ff @(posedge clk) begin
      if (srst || !cond_ok) begin
        qual_reg <= 28'h0000000;
      end else if (qual_reg != QUAL_CYC[27:0]) begin
        qual_reg <= qual_reg + 28'h0000001;
      end
    end

    assign qual_done = cond_ok && (qual_reg == QUAL_CYC[27:0]);

    always_ff @(posedge clk) begin
      if (srst) begin
        qual_q_reg <= 1'b0;
      end else begin
        qual_q_reg <= qual_done;
      end
    end

    // a recorded fault holds the switch off only while its retry bit is clear
    assign blocked = (!ctrl_reg[0] && fault_reg[0]) || (!ctrl_reg[1] && fault_reg[1])
                     || (!ctrl_reg[2] && fault_reg[2]) || cool_reg;
    // on-request is not qualified, so a rising edge acts at once
    assign go_w[i] = qual_done && ctrl_reg[`DCSFC_B_ON] && !blocked;
    assign go_eff = sh_reg.link_indep ? go_w[i] : (go_w[0] && go_w[1]);

    // ------------------------------------------------------------
    // start-up and run state
    // ------------------------------------------------------------
    assign start_end = sh_reg.internal_timer ? (tmr_reg == 28'h0000000) : sh_reg.timer_high;
    assign trip = (st_reg == ST_START && start_end && s_reg.in_limit)
                  || (st_reg == ST_RUN && brk_f);

    always_ff @(posedge clk) begin
      if (srst) begin
        st_reg <= ST_OFF;
        tmr_reg <= 28'h0000000;
      end else begin
        case (st_reg)
          ST_OFF: begin
            if (go_eff) begin
              st_reg <= ST_START;
              tmr_reg <= QUAL_CYC[27:0];
            end
          end
          ST_START: begin
            if (!go_eff || trip) begin
              st_reg <= ST_OFF;
            end else if (start_end) begin
              st_reg <= ST_RUN;
            end else if (tmr_reg != 28'h0000000) begin
              tmr_reg <= tmr_reg - 28'h0000001;
            end
          end
          ST_RUN: begin
            if (!go_eff || trip) begin
              st_reg <= ST_OFF;
            end
          end
          default: begin
            st_reg <= ST_OFF;
          end
        endcase
      end
    end

    // ------------------------------------------------------------
    // cool-down after a current fault
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
      if (srst) begin
        cool_reg <= 1'b0;
        need_pin_reg <= 1'b0;
        cool_cnt_reg <= 28'h0000000;
      end else if (trip) begin
        cool_reg <= 1'b1;
        need_pin_reg <= !sh_reg.internal_timer;
        cool_cnt_reg <= sh_reg.internal_timer ? COOL_CYC[27:0] : QUAL_CYC[27:0];
      end else if (on_fall && cool_reg) begin
        need_pin_reg <= 1'b0;
        cool_cnt_reg <= QUAL_CYC[27:0];
      end else if (cool_reg) begin
        if (cool_cnt_reg != 28'h0000000) begin
          cool_cnt_reg <= cool_cnt_reg - 28'h0000001;
        end else if (!need_pin_reg || sh_reg.timer_low) begin
          cool_reg <= 1'b0;
        end
      end
    end

    // ------------------------------------------------------------
    // fault record
    // ------------------------------------------------------------
    assign pbad = st_reg == ST_RUN && s_reg.gs_enhanced && !s_reg.output_feedback_sense;
    assign pres = {2'b00, pbad, 1'b0, lo_f, hi_f};

    always_comb begin
      fault_next = fault_reg;
      if (wr && addr == A_FAULT) begin
        fault_next = wdata[5:0] | (fault_reg & pres);
      end
      if (on_fall) begin
        fault_next = fault_next & pres;
      end
      if (insert) begin
        fault_next = fault_next & (pres | 6'h10);
      end
      // hardware sets come last: an event in the clearing cycle is kept
      fault_next[`DCSFC_B_HI] = fault_next[`DCSFC_B_HI] | hi_f;
      fault_next[`DCSFC_B_LO] = fault_next[`DCSFC_B_LO] | lo_f
                                | (pu_pend_reg && !sh_reg.internal_supply_low
                                   && s_reg.input_low_sense);
      fault_next[`DCSFC_B_CUR] = fault_next[`DCSFC_B_CUR] | trip;
      fault_next[`DCSFC_B_PBAD] = fault_next[`DCSFC_B_PBAD] | pbad;
      fault_next[`DCSFC_B_BOARD] = fault_next[`DCSFC_B_BOARD] | insert | remove;
    end

    always_ff @(posedge clk) begin
      if (srst) begin
        fault_reg <= `DCSFC_FAULT_RST;
      end else begin
        fault_reg <= fault_next;
      end
    end

    // ------------------------------------------------------------
    // outputs and status
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
      if (srst) begin
        pg_reg <= 1'b0;
        fo_reg <= 1'b0;
      end else begin
        pg_reg <= st_reg == ST_RUN && s_reg.output_feedback_sense && s_reg.gs_enhanced;
        fo_reg <= vdd_f || supply_f;
      end
    end

    assign gate_on[i] = st_reg != ST_OFF;
    assign fast_off[i] = fo_reg;
    assign power_good[i] = pg_reg;
    assign ctrl_w[i] = ctrl_reg;
    assign fault_w[i] = fault_reg;
    // bit 3 low means power good
    assign stat_w[i] = {!s_reg.board_absent, !pg_reg, cool_reg, lo_f, hi_f};
  end

  // ------------------------------------------------------------
  // register read port
  // ------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (srst || !rd) begin
      rdata_reg <= 8'h00;
    end else begin
      case (addr)
        `DCSFC_A_CTRL0: rdata_reg <= {4'h0, ctrl_w[0]};
        `DCSFC_A_CTRL1: rdata_reg <= {4'h0, ctrl_w[1]};
        `DCSFC_A_FAULT0: rdata_reg <= {2'b00, fault_w[0]};
        `DCSFC_A_FAULT1: rdata_reg <= {2'b00, fault_w[1]};
        `DCSFC_A_STAT0: rdata_reg <= {3'b000, stat_w[0]};
        `DCSFC_A_STAT1: rdata_reg <= {3'b000, stat_w[1]};
        default: rdata_reg <= 8'h00;
      endcase
    end
  end

  assign rdata = rdata_reg;
endmodule : dcsfc_top

// ---- test/dcsfc_far_model.sv ----
// behavioural pass switch and output comparators on the far side
// ------------------------------------------------------------
// far side model
// ------------------------------------------------------------
module dcsfc_far_model (
  input wire logic clk,
  input wire logic [1:0] gate_on,
  input wire logic [1:0] short_on,
  output logic [1:0] in_limit,
  output logic [1:0] fb_ok,
  output logic [1:0] gs_full
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [2:0] age [2];
  // gate ramps slowly; feedback crosses before full enhancement, so no power-bad
  always_ff @(posedge clk) begin
    for (int i = 0; i < 2; i++) begin
      if (gate_on[i] !== 1'b1) begin
        age[i] <= 3'h0;
      end else if (age[i] != 3'h7) begin
        age[i] <= age[i] + 3'h1;
      end
    end
  end
  // a shorted load keeps the switch in current limit with the output low
  always_comb begin
    for (int i = 0; i < 2; i++) begin
      in_limit[i] = (gate_on[i] === 1'b1) && short_on[i];
      fb_ok[i] = (gate_on[i] === 1'b1) && !short_on[i] && age[i] >= 3'h2;
      gs_full[i] = (gate_on[i] === 1'b1) && !short_on[i] && age[i] >= 3'h4;
    end
  end
endmodule : dcsfc_far_model

// ---- test/dcsfc_checker.sv ----
// port-level assertions for the switch fault control
// ------------------------------------------------------------
// checker
// ------------------------------------------------------------
module dcsfc_checker #(
  parameter int unsigned QUAL_CYC = 200,
  parameter int unsigned COOL_CYC = 400
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  input wire logic [7:0] rdata,
  input wire dcsfc_pkg::dcsfc_ch_in_s [1:0] ch_in,
  input wire dcsfc_pkg::dcsfc_sh_in_s sh_in,
  input wire logic [1:0] gate_on,
  input wire logic [1:0] fast_off,
  input wire logic [1:0] power_good
);
  import dcsfc_pkg::*;
  // limits: filter count plus sync and state margin
  localparam logic [10:0] FILT_MAX = 11'h06E;
  localparam logic [10:0] SUP_MAX = 11'h03C;
  localparam logic [10:0] BRK_MAX = 11'h3F2;
  localparam logic [10:0] FB_MAX = 11'h008;
  logic [10:0] hi_c [2];
  logic [10:0] lo_c [2];
  logic [10:0] vd_c;
  logic [10:0] br_c;
  logic [10:0] is_c;
  logic [10:0] fb_c;
  logic [3:0] lk_c;
  function automatic logic [10:0] up(input logic [10:0] c, input logic l);
    return l ? ((c == 11'h7FF) ? c : c + 11'h001) : 11'h000;
  endfunction : up
  // saturating run-length counters of the raw inputs
  always_ff @(posedge clk) begin
    if (srst) begin
      hi_c <= '{default: 11'h000};
      lo_c <= '{default: 11'h000};
      vd_c <= 11'h000;
      br_c <= 11'h000;
      is_c <= 11'h000;
      fb_c <= 11'h000;
      lk_c <= 4'h0;
    end else begin
      for (int i = 0; i < 2; i++) begin
        hi_c[i] <= up(hi_c[i], ch_in[i].input_high_sense);
        lo_c[i] <= up(lo_c[i], ch_in[i].input_low_sense);
      end
      vd_c <= up(vd_c, ch_in[1].vdd_low);
      br_c <= up(br_c, ch_in[0].breaker);
      is_c <= up(is_c, sh_in.internal_supply_low);
      fb_c <= up(fb_c, !ch_in[0].output_feedback_sense);
      lk_c <= sh_in.link_indep ? 4'h0 : ((lk_c == 4'hF) ? lk_c : lk_c + 4'h1);
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);
  sequence s_on_fall; $fell(ch_in[0].on_req); endsequence
  sequence s_removal; $rose(ch_in[0].board_absent); endsequence
  sequence s_gate_drop; ##[1:8] !gate_on[0]; endsequence
  property p_on_fall; s_on_fall |-> s_gate_drop; endproperty
  property p_removal; s_removal |-> s_gate_drop; endproperty
  property p_hi_off; hi_c[0] > FILT_MAX |-> !gate_on[0]; endproperty
  property p_lo_off; lo_c[0] > FILT_MAX |-> !gate_on[0]; endproperty
  property p_vdd_fast; vd_c > FILT_MAX |-> fast_off[1]; endproperty
  property p_sup_fast; is_c > SUP_MAX |-> fast_off == 2'b11; endproperty
  property p_brk_trip; br_c > BRK_MAX |-> !gate_on[0]; endproperty
  property p_link_fault;
    !sh_in.link_indep && lk_c > 4'h2 && (hi_c[0] > FILT_MAX || hi_c[1] > FILT_MAX)
      |-> gate_on == 2'b00;
  endproperty
  property p_link_same; lk_c > 4'h8 |-> gate_on[0] == gate_on[1]; endproperty
  property p_pg_rise; $rose(power_good[0]) |-> gate_on[0]; endproperty
  property p_pg_drop; fb_c > FB_MAX |-> !power_good[0]; endproperty
  a_on_fall: assert property (p_on_fall) else $error("gate on after on fall");
  a_removal: assert property (p_removal) else $error("gate on after removal");
  a_hi_off: assert property (p_hi_off) else $error("gate on in high input");
  a_lo_off: assert property (p_lo_off) else $error("gate on in low input");
  a_vdd_fast: assert property (p_vdd_fast) else $error("no fast off on vdd");
  a_sup_fast: assert property (p_sup_fast) else $error("no fast off on supply");
  a_brk_trip: assert property (p_brk_trip) else $error("breaker did not trip");
  a_link_fault: assert property (p_link_fault) else $error("linked not off");
  a_link_same: assert property (p_link_same) else $error("linked gates differ");
  a_pg_rise: assert property (p_pg_rise) else $error("good with gate off");
  a_pg_drop: assert property (p_pg_drop) else $error("good with feedback low");
endmodule : dcsfc_checker

bind dcsfc_top dcsfc_checker #(.QUAL_CYC(QUAL_CYC), .COOL_CYC(COOL_CYC)) u_dcsfc_checker (
  .clk(clk), .srst(srst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
  .ch_in(ch_in), .sh_in(sh_in), .gate_on(gate_on), .fast_off(fast_off),
  .power_good(power_good)
);

// ---- test/test_dcsfc_top.sv ----
// self-checking bench for the switch fault control
module test_dcsfc_top;
  timeunit 1ns;
  timeprecision 1ps;
  // short counts keep the run small
  localparam int unsigned QUAL = 200;
  localparam int unsigned COOL = 400;
  logic clk = 1'b0;
  logic srst;
  logic [7:0] addr;
  logic [7:0] wdata;
  logic wr;
  logic rd;
  logic [7:0] rdata;
  logic [1:0] on_req, hi, lo, absent, brk, vdd, short_on, lim, fb, gs;
  dcsfc_pkg::dcsfc_ch_in_s [1:0] ch_in;
  dcsfc_pkg::dcsfc_sh_in_s sh_in;
  logic [1:0] gate_on;
  logic [1:0] fast_off;
  logic [1:0] power_good;
  int n_mismatch = 0;
  int cmp_count = 0;
  always #10 clk = ~clk;
  always_comb begin
    for (int i = 0; i < 2; i++) begin
      ch_in[i] = '{on_req[i], hi[i], lo[i], absent[i], brk[i], lim[i], fb[i], gs[i], vdd[i]};
    end
  end
  dcsfc_top #(.QUAL_CYC(QUAL), .COOL_CYC(COOL)) u_dcsfc_top (
    .clk(clk), .srst(srst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
    .ch_in(ch_in), .sh_in(sh_in), .gate_on(gate_on), .fast_off(fast_off),
    .power_good(power_good)
  );
  dcsfc_far_model u_dcsfc_far_model (
    .clk(clk), .gate_on(gate_on), .short_on(short_on), .in_limit(lim), .fb_ok(fb),
    .gs_full(gs)
  );
  // ------------------------------------------------------------
  // tasks
  // ------------------------------------------------------------
  task automatic final_report();
    $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : final_report
  task automatic chk_reg(input string name, input logic [7:0] exp, input logic [7:0] got);
    cmp_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", name, exp, got);
    end
  endtask : chk_reg
  task automatic chk_pin(input string name, input logic [1:0] exp, input logic [1:0] got);
    cmp_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch %s expected %b seen %b", name, exp, got);
    end
  endtask : chk_pin
  // ends just after an edge so outputs have settled
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : cyc
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wr_reg
  task automatic rd_reg(input string name, input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    chk_reg(name, exp, rdata);
  endtask : rd_reg
  // bounded wait; running out shows up as a gate mismatch
  task automatic wait_gate(input logic [1:0] exp, input int max);
    for (int i = 0; i < max && gate_on !== exp; i++) begin
      cyc(1);
    end
    chk_pin("gate_on", exp, gate_on);
  endtask : wait_gate
  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    srst = 1'b1;
    addr = 8'h00;
    wdata = 8'h00;
    wr = 1'b0;
    rd = 1'b0;
    {on_req, hi, lo, absent, brk, vdd, short_on} = 14'h0000;
    sh_in = '{1'b0, 1'b1, 1'b0, 1'b1, 1'b1};
    cyc(12);
    srst <= 1'b0;
    rd_reg("ctrl0", 8'h00, 8'h03);
    rd_reg("ctrl1", 8'h04, 8'h03);
    rd_reg("fault0", 8'h08, 8'h00);
    wr_reg(8'h20, 8'hFF);
    rd_reg("unmapped", 8'h20, 8'h00);
    cyc(QUAL + 20);
    on_req[0] <= 1'b1;
    wait_gate(2'b01, 8);
    rd_reg("ctrl0", 8'h00, 8'h0B);
    cyc(QUAL + 20);
    chk_pin("power_good", 2'b01, power_good);
    for (int b = 0; b < 2; b++) begin
      {lo[0], hi[0]} <= b ? 2'b10 : 2'b01;
      cyc(150);
      chk_pin("gate_on", 2'b00, gate_on);
      wr_reg(8'h08, 8'h00);
      rd_reg("fault0", 8'h08, b ? 8'h02 : 8'h01);
      rd_reg("stat0", 8'h10, b ? 8'h1A : 8'h19);
      {lo[0], hi[0]} <= 2'b00;
      wait_gate(2'b01, 3 * QUAL);
      wr_reg(8'h08, 8'h00);
      rd_reg("fault0", 8'h08, 8'h00);
      cyc(QUAL + 20);
    end
    wr_reg(8'h08, 8'h04);
    cyc(8);
    chk_pin("gate_on", 2'b00, gate_on);
    on_req[0] <= 1'b0;
    cyc(10);
    on_req[0] <= 1'b1;
    wait_gate(2'b01, QUAL + 50);
    cyc(QUAL + 20);
    brk[0] <= 1'b1;
    cyc(1100);
    brk[0] <= 1'b0;
    chk_pin("gate_on", 2'b00, gate_on);
    rd_reg("fault0", 8'h08, 8'h04);
    cyc(COOL + QUAL + 50);
    chk_pin("gate_on", 2'b00, gate_on);
    wr_reg(8'h00, 8'h0F);
    wait_gate(2'b01, COOL + QUAL);
    short_on[0] <= 1'b1;
    on_req[0] <= 1'b0;
    cyc(10);
    on_req[0] <= 1'b1;
    wait_gate(2'b01, QUAL + 50);
    wait_gate(2'b00, QUAL + 50);
    rd_reg("fault0", 8'h08, 8'h04);
    short_on[0] <= 1'b0;
    wait_gate(2'b01, COOL + QUAL + 50);
    wr_reg(8'h00, 8'h07);
    wait_gate(2'b00, 8);
    wr_reg(8'h00, 8'h0F);
    short_on[0] <= 1'b1;
    wait_gate(2'b01, 8);
    wait_gate(2'b00, QUAL + 50);
    on_req[0] <= 1'b0;
    cyc(10);
    on_req[0] <= 1'b1;
    short_on[0] <= 1'b0;
    wait_gate(2'b01, QUAL + 50);
    cyc(QUAL + 20);
    absent[0] <= 1'b1;
    wait_gate(2'b00, 8);
    rd_reg("stat0", 8'h10, 8'h08);
    sh_in.link_indep <= 1'b0;
    absent[0] <= 1'b0;
    vdd[1] <= 1'b1;
    cyc(120);
    chk_pin("fast_off", 2'b10, fast_off);
    vdd[1] <= 1'b0;
    sh_in.internal_supply_low <= 1'b1;
    cyc(70);
    chk_pin("fast_off", 2'b11, fast_off);
    sh_in.internal_supply_low <= 1'b0;
    on_req[1] <= 1'b1;
    wait_gate(2'b11, 4 * QUAL);
    hi[1] <= 1'b1;
    cyc(120);
    chk_pin("gate_on", 2'b00, gate_on);
    hi[1] <= 1'b0;
    srst <= 1'b1;
    lo[0] <= 1'b1;
    cyc(12);
    srst <= 1'b0;
    cyc(10);
    rd_reg("fault0", 8'h08, 8'h02);
    final_report();
  end
endmodule : test_dcsfc_top
